// ==== rtl/fcp_pkg.sv ====
// package of constants and types for the flash and configuration page engine
package fcp_pkg;
    // ****************************************
    // sfr addresses
    // ****************************************
    localparam logic [7:0] ADDR_DATA_PORT  = 8'hE2;
    localparam logic [7:0] ADDR_ADDR_HIGH  = 8'hE3;
    localparam logic [7:0] ADDR_ADDR_LOW   = 8'hE4;
    localparam logic [7:0] ADDR_OP_SELECT  = 8'hE5;
    localparam logic [7:0] ADDR_CMD_PORT   = 8'hE6;
    localparam logic [7:0] ADDR_ACCESS_CTL = 8'hE7;
    // configuration page index of the boundary register
    localparam logic [7:0] CFG_APP_LOW_BOUND = 8'h03;
    // ****************************************
    // access control fields
    // ****************************************
    localparam int BIT_ACCESS_ENABLE = 7;
    localparam int BIT_BOOT_SELECT   = 6;
    localparam int BIT_SOFT_RESET    = 5;
    localparam int BIT_CMD_FAILED    = 4;
    // ****************************************
    // reset values and commands
    // ****************************************
    localparam logic [7:0] RST_DATA_PORT     = 8'hFF;
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [7:0] RST_APP_LOW_BOUND = 8'hFE;
    localparam logic [7:0] UNLOCK_FIRST      = 8'h46;
    localparam logic [7:0] UNLOCK_SECOND     = 8'hB9;
    localparam logic [7:0] OP_STANDBY        = 8'h00;
    localparam logic [7:0] OP_BYTE_READ      = 8'h01;
    localparam logic [7:0] OP_BYTE_PROG      = 8'h02;
    localparam logic [7:0] OP_PAGE_ERASE     = 8'h03;
    localparam logic [7:0] OP_CFG_WRITE      = 8'h04;
    localparam logic [7:0] OP_CFG_READ       = 8'h05;
    localparam logic [7:0] OP_CRC_READ       = 8'h80;
    localparam logic [7:0] OP_READ_INC       = 8'h81;
    localparam logic [7:0] OP_PROG_INC       = 8'h82;
    localparam int         PAGE_BYTES        = 512;
    localparam int         BOUND_SCALE       = 256;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {FCP_IDLE, FCP_ARMED, FCP_RUN, FCP_ERASE, FCP_DONE} fcp_state_e;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcp_sfr_req_s;
endpackage

// ==== rtl/fcp_engine.sv ====
// flash and configuration page command engine
`timescale 1ns/1ps
module fcp_engine
    import fcp_pkg::*;
#(
    parameter int          AW         = 16,
    parameter logic [15:0] BOOT_START = 16'hFA00,
    parameter int          OP_CYCLES  = 4
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // cpu sfr access
    input  wire fcp_pkg::fcp_sfr_req_s sfr_req,
    output logic [7:0]              sfr_rdata,
    // cpu control
    output logic                    cpu_halt,
    output logic                    soft_reset,
    output logic                    boot_select,
    // flash array
    output logic [AW-1:0]           fl_addr,
    output logic [7:0]              fl_wdata,
    input  wire logic [7:0]         fl_rdata
);
    import fcp_pkg::*;

    localparam int          ERASE_CNT = PAGE_BYTES;
    localparam logic [9:0]  OP_LAST   = 10'(OP_CYCLES - 1);

    // ****************************************
    // reset synchroniser
    // ****************************************
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ****************************************
    // flash memory array
    // ****************************************
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] cfg [0:255];

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]   data_r, addr_h_r, addr_l_r, op_r;
    logic         en_r, boot_r, soft_reset_request_r, fail_r, halt_r;
    fcp_state_e   st_r;
    logic [9:0]   cnt_r;
    logic [7:0]   rdata_r;
    logic [AW-1:0] fl_addr_r;
    logic [7:0]   fl_wdata_r;

    // ****************************************
    // decode
    // ****************************************
    wire         wr_cmd   = sfr_req.wr && sfr_req.addr == ADDR_CMD_PORT;
    wire         wr_ctl   = sfr_req.wr && sfr_req.addr == ADDR_ACCESS_CTL;
    wire         first_ok = wr_cmd && sfr_req.wdata == UNLOCK_FIRST;
    wire         trigger  = st_r == FCP_ARMED && wr_cmd && sfr_req.wdata == UNLOCK_SECOND && en_r;
    wire [15:0]  tgt      = {addr_h_r, addr_l_r};
    wire [15:0]  low_bnd  = 16'(cfg[CFG_APP_LOW_BOUND]) * 16'(BOUND_SCALE);
    wire         in_app   = tgt >= low_bnd && tgt <= BOOT_START - 16'h0001;
    wire         is_flash = op_r == OP_BYTE_READ || op_r == OP_BYTE_PROG || op_r == OP_PAGE_ERASE ||
                            op_r == OP_READ_INC || op_r == OP_PROG_INC || op_r == OP_CRC_READ;
    wire         is_cfg   = op_r == OP_CFG_WRITE || op_r == OP_CFG_READ;
    wire         op_ok    = (is_flash && in_app) || is_cfg;
    wire         inc_op   = op_r == OP_READ_INC || op_r == OP_PROG_INC;
    wire [AW-1:0] page_base = AW'({addr_h_r[7:1], 9'h000});
    wire [7:0]   ctl_rd   = {en_r, boot_r, soft_reset_request_r, fail_r, 4'h0};

    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] rd_nxt;
    always_comb begin
        case (sfr_req.addr)
            ADDR_DATA_PORT:  rd_nxt = data_r;
            ADDR_ADDR_HIGH:  rd_nxt = addr_h_r;
            ADDR_ADDR_LOW:   rd_nxt = addr_l_r;
            ADDR_OP_SELECT:  rd_nxt = op_r;
            ADDR_ACCESS_CTL: rd_nxt = ctl_rd;
            default:         rd_nxt = RST_ZERO;
        endcase
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            data_r     <= RST_DATA_PORT;
            addr_h_r   <= RST_ZERO;
            addr_l_r   <= RST_ZERO;
            op_r       <= OP_STANDBY;
            en_r       <= 1'b0;
            boot_r     <= 1'b0;
            soft_reset_request_r    <= 1'b0;
            fail_r     <= 1'b0;
            halt_r     <= 1'b0;
            st_r       <= FCP_IDLE;
            cnt_r      <= 10'h000;
            rdata_r    <= RST_ZERO;
            fl_addr_r  <= '0;
            fl_wdata_r <= RST_ZERO;
            for (int i = 0; i < 256; i++) begin
                cfg[i] <= (8'(i) == CFG_APP_LOW_BOUND) ? RST_APP_LOW_BOUND : RST_ZERO;
            end
        end else begin
            soft_reset_request_r <= 1'b0;
            if (sfr_req.rd) begin
                rdata_r <= rd_nxt;
            end
            if (sfr_req.wr && !halt_r) begin
                case (sfr_req.addr)
                    ADDR_DATA_PORT: data_r   <= sfr_req.wdata;
                    ADDR_ADDR_HIGH: addr_h_r <= sfr_req.wdata;
                    ADDR_ADDR_LOW:  addr_l_r <= sfr_req.wdata;
                    ADDR_OP_SELECT: op_r     <= sfr_req.wdata;
                    default: ;
                endcase
            end
            if (wr_ctl && !halt_r) begin
                en_r    <= sfr_req.wdata[BIT_ACCESS_ENABLE];
                boot_r  <= sfr_req.wdata[BIT_BOOT_SELECT];
                soft_reset_request_r <= sfr_req.wdata[BIT_SOFT_RESET];
            end
            case (st_r)
                FCP_IDLE: begin
                    if (first_ok) begin
                        st_r <= FCP_ARMED;
                    end
                end
                FCP_ARMED: begin
                    if (trigger) begin
                        halt_r <= 1'b1;
                        cnt_r  <= 10'h000;
                        if (!op_ok) begin
                            fail_r <= 1'b1;
                            st_r   <= FCP_DONE;
                        end else if (op_r == OP_PAGE_ERASE) begin
                            fl_addr_r <= page_base;
                            st_r      <= FCP_ERASE;
                        end else begin
                            st_r <= FCP_RUN;
                        end
                    end else if (wr_cmd) begin
                        st_r <= first_ok ? FCP_ARMED : FCP_IDLE;
                    end
                end
                FCP_RUN: begin
                    cnt_r <= cnt_r + 10'h001;
                    if (cnt_r == OP_LAST) begin
                        fail_r <= 1'b0;
                        case (op_r)
                            OP_BYTE_READ, OP_READ_INC, OP_CRC_READ: data_r <= mem[AW'(tgt)];
                            OP_BYTE_PROG, OP_PROG_INC: mem[AW'(tgt)] <= data_r;
                            OP_CFG_WRITE: cfg[addr_l_r] <= data_r;
                            OP_CFG_READ:  data_r <= cfg[addr_l_r];
                            default: ;
                        endcase
                        fl_addr_r  <= AW'(tgt);
                        fl_wdata_r <= data_r;
                        if (inc_op) begin
                            {addr_h_r, addr_l_r} <= tgt + 16'h0001;
                        end
                        st_r <= FCP_DONE;
                    end
                end
                FCP_ERASE: begin
                    mem[fl_addr_r] <= 8'hFF;
                    fl_addr_r <= fl_addr_r + AW'(1);
                    cnt_r     <= cnt_r + 10'h001;
                    if (cnt_r == 10'(ERASE_CNT - 1)) begin
                        fail_r <= 1'b0;
                        st_r   <= FCP_DONE;
                    end
                end
                FCP_DONE: begin
                    halt_r <= 1'b0;
                    st_r   <= FCP_IDLE;
                end
                default: st_r <= FCP_IDLE;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign sfr_rdata   = rdata_r;
    assign cpu_halt    = halt_r;
    assign soft_reset  = soft_reset_request_r;
    assign boot_select = boot_r;
    assign fl_addr     = fl_addr_r;
    assign fl_wdata    = fl_wdata_r;
endmodule // fcp_engine

// ==== verification/fcp_engine_props.sv ====
// assertions on the ports of the flash and configuration page engine
`timescale 1ns/1ps
module fcp_engine_props
    import fcp_pkg::*;
#(parameter int AW = 16) (
    // watched ports
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire fcp_pkg::fcp_sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata,
    input wire logic                  cpu_halt,
    input wire logic                  soft_reset,
    input wire logic                  boot_select,
    input wire logic [AW-1:0]         fl_addr,
    input wire logic [7:0]            fl_wdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic cmd_wr    = sfr_req.wr && sfr_req.addr == ADDR_CMD_PORT && !cpu_halt;
    wire logic ctl_wr    = sfr_req.wr && sfr_req.addr == ADDR_ACCESS_CTL && !cpu_halt;
    wire logic second_wr = cmd_wr && sfr_req.wdata == UNLOCK_SECOND;
    wire logic bs_in     = sfr_req.wdata[BIT_BOOT_SELECT];
    property p_start; $rose(cpu_halt) |-> $past(second_wr); endproperty
    a_start: assert property (p_start) else $error("halt rose without unlock byte");
    property p_sr; ctl_wr && sfr_req.wdata[BIT_SOFT_RESET] |=> soft_reset ##1 !soft_reset; endproperty
    a_sr: assert property (p_sr) else $error("soft reset not a single pulse");
    property p_nosr; !ctl_wr || !sfr_req.wdata[BIT_SOFT_RESET] |=> !soft_reset; endproperty
    a_nosr: assert property (p_nosr) else $error("soft reset without request");
    property p_boot; ctl_wr |=> boot_select == $past(bs_in); endproperty
    a_boot: assert property (p_boot) else $error("boot select not written");
    property p_boot_hold; !ctl_wr |=> $stable(boot_select); endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot select moved");
    property p_rdhold; !sfr_req.rd |=> $stable(sfr_rdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved without read");
    property p_halt_len; $rose(cpu_halt) |-> ##[1:513] !cpu_halt; endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt too long");
    property p_touch; $changed(fl_addr) || $changed(fl_wdata) |-> cpu_halt; endproperty
    a_touch: assert property (p_touch) else $error("flash touched outside operation");
    c_long: cover property (cpu_halt [*8]);
    c_done: cover property ($fell(cpu_halt));
    c_sr: cover property (soft_reset);
endmodule // fcp_engine_props
bind fcp_engine fcp_engine_props #(.AW(AW)) fcp_engine_props_inst (.sys_clk(sys_clk), .rstn(rstn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cpu_halt(cpu_halt), .soft_reset(soft_reset),
    .boot_select(boot_select), .fl_addr(fl_addr), .fl_wdata(fl_wdata));

// ==== verification/tb_top.sv ====
// self-checking bench for the flash and configuration page engine
`timescale 1ns/1ps
module tb_top;
    import fcp_pkg::*;
    localparam int DLY = 1;
    logic         sys_clk = 1'b0;
    logic         rstn = 1'b0;
    fcp_sfr_req_s req = '0;
    logic [7:0]   sfr_rdata, fl_wdata;
    logic         cpu_halt, soft_reset, boot_select;
    logic [15:0]  fl_addr;
    int           fail_count = 0;
    int           n_tests = 0;
    int           cyc = 0;
    fcp_engine #(.AW(16), .BOOT_START(16'hFA00), .OP_CYCLES(4)) fcp_engine_inst (.sys_clk(sys_clk),
        .rstn(rstn), .sfr_req(req), .sfr_rdata(sfr_rdata), .cpu_halt(cpu_halt), .soft_reset(soft_reset),
        .boot_select(boot_select), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(8'h00));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #DLY;
        req = '{w, ~w, a, d};
        @(posedge sys_clk);
        #DLY;
        req = '0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, exp});
    endtask
    task automatic setop(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
        acc(1'b1, ADDR_DATA_PORT, d);
        acc(1'b1, ADDR_ADDR_HIGH, hi);
        acc(1'b1, ADDR_ADDR_LOW, lo);
        acc(1'b1, ADDR_OP_SELECT, m);
    endtask
    task automatic go(input logic [7:0] first, input int exp_n);
        int n;
        n = 0;
        acc(1'b1, ADDR_CMD_PORT, first);
        acc(1'b1, ADDR_CMD_PORT, UNLOCK_SECOND);
        for (int i = 0; i < 600; i++) begin
            if (cpu_halt === 1'b1) n++;
            else if (n > 0 || i > 4) break;
            @(posedge sys_clk);
            #DLY;
        end
        chk("cpu_halt cycles", n[15:0], exp_n[15:0]);
    endtask
    task automatic t_reset();
        rdc(ADDR_DATA_PORT, RST_DATA_PORT);
        rdc(ADDR_ACCESS_CTL, RST_ZERO);
        rdc(8'h10, RST_ZERO);
    endtask
    task automatic t_cfg();
        setop(OP_CFG_WRITE, 8'h00, CFG_APP_LOW_BOUND, 8'h11);
        go(UNLOCK_FIRST, 0);
        acc(1'b1, ADDR_ACCESS_CTL, 8'h80);
        setop(OP_CFG_READ, 8'h00, CFG_APP_LOW_BOUND, 8'h00);
        go(UNLOCK_FIRST, 5);
        rdc(ADDR_DATA_PORT, RST_APP_LOW_BOUND);
        setop(OP_CFG_WRITE, 8'h00, CFG_APP_LOW_BOUND, 8'hC0);
        go(UNLOCK_FIRST, 5);
        setop(OP_CFG_READ, 8'h00, CFG_APP_LOW_BOUND, 8'h00);
        go(UNLOCK_FIRST, 5);
        rdc(ADDR_DATA_PORT, 8'hC0);
    endtask
    task automatic t_flash();
        setop(OP_BYTE_PROG, 8'hC1, 8'h05, 8'h5A);
        go(UNLOCK_FIRST, 5);
        chk("fl_addr", fl_addr, 16'hC105);
        chk("fl_wdata", {8'h00, fl_wdata}, 16'h005A);
        rdc(ADDR_ACCESS_CTL, 8'h80);
        setop(OP_BYTE_READ, 8'hC1, 8'h05, 8'h00);
        go(UNLOCK_FIRST, 5);
        rdc(ADDR_DATA_PORT, 8'h5A);
        setop(OP_BYTE_PROG, 8'hBF, 8'hFF, 8'h33);
        go(UNLOCK_FIRST, 1);
        rdc(ADDR_ACCESS_CTL, 8'h90);
        setop(OP_BYTE_PROG, 8'hFA, 8'h00, 8'h33);
        go(UNLOCK_FIRST, 1);
        setop(OP_BYTE_PROG, 8'hC0, 8'h00, 8'h33);
        go(UNLOCK_FIRST, 5);
        rdc(ADDR_ACCESS_CTL, 8'h80);
    endtask
    task automatic t_erase();
        setop(OP_PAGE_ERASE, 8'hC1, 8'h77, 8'h00);
        go(UNLOCK_FIRST, 513);
        setop(OP_READ_INC, 8'hC0, 8'h00, 8'h00);
        go(UNLOCK_FIRST, 5);
        rdc(ADDR_DATA_PORT, 8'hFF);
        rdc(ADDR_ADDR_LOW, 8'h01);
    endtask
    task automatic t_ctl();
        acc(1'b1, ADDR_CMD_PORT, UNLOCK_FIRST);
        go(8'h47, 0);
        acc(1'b1, ADDR_ACCESS_CTL, 8'hE0);
        chk("soft_reset", {15'h0, soft_reset}, 16'h0001);
        chk("boot_select", {15'h0, boot_select}, 16'h0001);
        rdc(ADDR_ACCESS_CTL, 8'hC0);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        #DLY;
        rstn = 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_cfg();
        t_flash();
        t_erase();
        t_ctl();
        give_verdict();
    end
endmodule // tb_top
